// file: ssp_pkg.sv
// Shared types and constants of the slave serial/parallel converter.
// Assumes one 40 MHz core clock; all other timing is derived from it.
package ssp_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_NS = 25;     // Core clock period, ns
  localparam int SYNC_NS = 50;    // Least stall time around a load, ns
  // Stall length in core cycles, rounded up
  localparam logic [1:0] SYNC_CYC =
    2'((SYNC_NS + CLK_NS - 1) / CLK_NS);

  // ****************************************************************
  // Word lengths and buffering
  // ****************************************************************
  localparam logic [4:0] WORD_BITS = 5'h10;  // Long transfer
  localparam logic [4:0] BYTE_BITS = 5'h08;  // Short transfer
  localparam int FIFO_WIDTH = 16;            // Received word width
  localparam int FIFO_DEPTH = 16;            // Received word slots

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [2:0] SEL_RST = 3'h7;     // Select idles high
  localparam logic [2:0] LINE_RST = 3'h0;    // Other synchronisers

  // Transfer sequencer, one-hot
  typedef enum logic [3:0] {
    st_idle  = 4'h1,
    st_load  = 4'h2,
    st_shift = 4'h4,
    st_done  = 4'h8
  } ssp_state_e;

  // Two 8-bit halves of the shift/parallel store
  typedef struct packed {
    logic [7:0] hi;   // Upper byte, bits 15:8
    logic [7:0] lo;   // Lower byte, bits 7:0
  } ssp_word_s;

  // Static configuration bits
  typedef struct packed {
    logic cpol;        // Idle clock level
    logic cpha;        // 0: sample leading edge, 1: trailing
    logic p2s;         // 0: serial_to_parallel, 1: parallel_to_serial
    logic len8;        // 0: 16 bits, 1: 8 bits (low byte)
    logic src_adc;     // Short load source: 0 counter zero, 1 ADC
    logic adc_buf_en;  // Low byte of the parallel word acts as ADC sample buffer
  } ssp_cfg_s;

  // Parallel sources for a load
  typedef struct packed {
    logic [7:0] cnt0;  // state_counter_zero value
    logic [7:0] cnt1;  // state_counter_one value, low eight bits
    logic [7:0] adc;   // ADC result
  } ssp_par_s;

  // Whole state of the converter
  typedef struct packed {
    ssp_state_e st;        // Sequencer state
    logic [2:0] sclk_q;    // Link clock synchroniser and history
    logic [2:0] sel_q;     // Select synchroniser and history
    logic [1:0] mosi_q;    // Serial input synchroniser
    logic [2:0] adck_q;    // ADC buffer clock synchroniser
    ssp_word_s sreg;       // Shift/parallel store
    logic [4:0] bitcnt;    // Bits sampled in this frame
    logic [1:0] synccnt;   // Cycles of stall left
    ssp_word_s word;       // Parallel word to the cells
    logic miso;            // Serial output bit
    logic oe_n;            // Serial output enable, low drives
    logic irq;             // Transfer done
    logic sync;            // Stall for the clocked cells
    logic push;            // Word offered to the buffer
    logic overrun;         // Word refused by a full buffer
    logic adc_pend;        // ADC capture one cycle later
  } ssp_regs_s;

endpackage : ssp_pkg

// file: ssp_fifo.sv
// Received-word buffer: a shifting queue of flip-flops.
// Assumes writer and reader share the core clock.
module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int CW = $clog2(DEPTH + 1);

  // Whole buffer state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Entry 0 is the head
    logic [CW-1:0] cnt;                // Words held
    logic vld;                         // Head holds a word
  } ssp_fifo_s;

  ssp_fifo_s s;
  ssp_fifo_s next_s;
  logic pop;
  logic push;
  logic [CW-1:0] wr_idx;

  // Full refuses writes
  assign in_ready_o = (s.cnt != CW'(DEPTH));
  assign out_valid_o = s.vld;
  assign out_data_o = s.mem[0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    pop = s.vld & out_ready_i;
    push = in_valid_i & in_ready_o;
    wr_idx = pop ? s.cnt - 1'b1 : s.cnt;
    // Shift every entry towards the head
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_s.mem[i] = s.mem[i + 1];
      end
      next_s.mem[DEPTH - 1] = '0;
    end
    // Write behind the last word held
    if (push) begin
      next_s.mem[wr_idx] = in_data_i;
    end
    next_s.cnt = s.cnt + CW'(push) - CW'(pop);
    next_s.vld = (next_s.cnt != '0);
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Count follows one accepted write
  a_fifo_count_up: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (push && !pop) |=> (s.cnt == $past(s.cnt) + 1'b1))
    else $error("Buffer count did not grow on a write");

endmodule : ssp_fifo

// file: ssp_converter.sv
// Slave serial/parallel converter with a received-word buffer.
// Assumes link clock, select and serial input arrive from outside the
// core clock domain and are slower than a quarter of the core clock.

module ssp_converter (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link from the routing fabric and pin
  input wire logic sclk_i,
  input wire logic chip_select_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  // Configuration
  input wire ssp_pkg::ssp_cfg_s cfg_i,
  // Parallel sources
  input wire ssp_pkg::ssp_par_s par_i,
  input wire logic adc_clk_i,
  // Parallel word and events
  output ssp_pkg::ssp_word_s rx_word_o,
  output logic irq_o,
  output logic sync_o,
  // Received-word stream
  output logic [ssp_pkg::FIFO_WIDTH-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic rx_overrun_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  ssp_pkg::ssp_regs_s s;       // Registered state
  ssp_pkg::ssp_regs_s next_s;  // Next state
  logic fifo_in_ready;         // Buffer can take a word
  logic rise;                  // Link clock rose
  logic fall;                  // Link clock fell
  logic samp;                  // Sampling edge of this mode
  logic chg;                   // Changing edge of this mode
  logic sel_fall;              // Frame starts
  logic sel_rise;              // Frame ends
  logic tx_ok;                 // Output direction allowed
  logic last;                  // This sample ends the word
  logic [15:0] shifted;        // Store with the new bit in

  // ****************************************************************
  // Edge and frame decode
  // ****************************************************************
  always_comb begin
    // Edges seen on the second synchroniser stage only
    rise = s.sclk_q[1] & ~s.sclk_q[2];
    fall = ~s.sclk_q[1] & s.sclk_q[2];
    // Same polarity and phase sample on rise, else on fall
    samp = (cfg_i.cpol == cfg_i.cpha) ? rise : fall;
    chg = (cfg_i.cpol == cfg_i.cpha) ? fall : rise;
    sel_fall = ~s.sel_q[1] & s.sel_q[2];
    sel_rise = s.sel_q[1] & ~s.sel_q[2];
    // Output direction needs phase 1
    tx_ok = cfg_i.p2s & cfg_i.cpha;
    // Word length from the length bit
    last = cfg_i.len8 ? (s.bitcnt == ssp_pkg::BYTE_BITS - 5'h01)
                      : (s.bitcnt == ssp_pkg::WORD_BITS - 5'h01);
    // Input bit enters at the bottom, MSB leaves first
    shifted = {s.sreg[14:0], s.mosi_q[1]};
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    // Synchronisers; first stage feeds only the second
    next_s.sclk_q = {s.sclk_q[1:0], sclk_i};
    next_s.sel_q = {s.sel_q[1:0], chip_select_n_i};
    next_s.mosi_q = {s.mosi_q[0], mosi_i};
    next_s.adck_q = {s.adck_q[1:0], adc_clk_i};
    // Pulses last one cycle
    next_s.push = 1'b0;
    next_s.adc_pend = 1'b0;
    // A word offered while full is lost and flagged
    next_s.overrun = s.push & ~fifo_in_ready;

    // ADC sample buffer, captured one cycle after the clock edge
    if (cfg_i.adc_buf_en && s.adck_q[1] && !s.adck_q[2]) begin
      next_s.adc_pend = 1'b1;
    end
    if (s.adc_pend) begin
      next_s.word.lo = par_i.adc;
    end

    unique case (s.st)
      // Wait for a frame
      ssp_pkg::st_idle: begin
        if (sel_fall) begin
          next_s.bitcnt = 5'h00;
          next_s.irq = 1'b0;
          if (tx_ok) begin
            // Drive the output and stall the cells for the load
            next_s.oe_n = 1'b0;
            next_s.sync = 1'b1;
            next_s.synccnt = ssp_pkg::SYNC_CYC - 2'h1;
            next_s.st = ssp_pkg::st_load;
          end else begin
            // Input only; with phase 0 the master presets bit one
            next_s.st = ssp_pkg::st_shift;
          end
        end
      end
      // Stall held, then take the parallel word
      ssp_pkg::st_load: begin
        if (s.synccnt == 2'h0) begin
          next_s.sync = 1'b0;
          if (cfg_i.len8) begin
            // Short word sits in the low byte
            next_s.sreg.hi = 8'h00;
            next_s.sreg.lo = cfg_i.src_adc ? par_i.adc
                                           : par_i.cnt0;
          end else begin
            next_s.sreg.hi = par_i.cnt0;
            next_s.sreg.lo = par_i.cnt1;
          end
          next_s.st = ssp_pkg::st_shift;
        end else begin
          next_s.synccnt = s.synccnt - 2'h1;
        end
      end
      // Move bits on the link edges
      ssp_pkg::st_shift: begin
        if (chg && cfg_i.p2s) begin
          // Present the next bit, MSB of the chosen length first
          next_s.miso = cfg_i.len8 ? s.sreg.lo[7]
                                   : s.sreg.hi[7];
          next_s.sreg = {s.sreg[14:0], 1'b0};
        end
        if (samp) begin
          next_s.bitcnt = s.bitcnt + 5'h01;
          if (!cfg_i.p2s) begin
            next_s.sreg = shifted;
          end
          if (last) begin
            next_s.irq = 1'b1;
            next_s.st = ssp_pkg::st_done;
            if (!cfg_i.p2s) begin
              // Upper byte to cells A, lower byte to cells B
              if (cfg_i.len8) begin
                next_s.word.lo = shifted[7:0];
              end else begin
                next_s.word = shifted;
              end
              next_s.push = 1'b1;
            end
          end
        end
      end
      // Word complete; wait for the frame to end
      ssp_pkg::st_done: begin
        next_s.st = ssp_pkg::st_done;
      end
    endcase

    // Frame end wins over every state
    if (sel_rise) begin
      next_s.st = ssp_pkg::st_idle;
      next_s.oe_n = 1'b1;
      next_s.irq = 1'b0;
      next_s.sync = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.st <= ssp_pkg::st_idle;
      s.sel_q <= ssp_pkg::SEL_RST;
      s.sclk_q <= ssp_pkg::LINE_RST;
      s.adck_q <= ssp_pkg::LINE_RST;
      s.oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Received-word buffer
  // ****************************************************************
  ssp_fifo #(
    .WIDTH(ssp_pkg::FIFO_WIDTH),
    .DEPTH(ssp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(s.push),
    .in_data_i(s.word),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o(rx_data_o),
    .out_ready_i(rx_ready_i)
  );

  // Outputs straight from the state register
  assign miso_o = s.miso;
  assign miso_oe_n_o = s.oe_n;
  assign rx_word_o = s.word;
  assign irq_o = s.irq;
  assign sync_o = s.sync;
  assign rx_overrun_o = s.overrun;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Start of an output frame
  sequence s_load_start;
    sel_fall && tx_ok && (s.st == ssp_pkg::st_idle);
  endsequence

  // Stall pulse of the documented length, then released
  sequence s_sync_pulse;
    sync_o [*2] ##1 !sync_o;
  endsequence

  a_oe_on_select: assert property (
    s_load_start |=> !miso_oe_n_o)
    else $error("Output not enabled at select fall");

  a_oe_off_deselect: assert property (
    sel_rise |=> miso_oe_n_o)
    else $error("Output not released at select rise");

  a_sync_on_load: assert property (
    s_load_start |=> s_sync_pulse)
    else $error("Stall pulse wrong around the load");

  a_phase0_rx_only: assert property (
    (sel_fall && !cfg_i.cpha) |=> miso_oe_n_o)
    else $error("Output driven with phase 0");

  a_irq_last_bit: assert property (
    (s.st == ssp_pkg::st_shift && samp && last && !sel_rise)
    |=> irq_o)
    else $error("Interrupt missing after last bit");

  a_irq_clear: assert property (
    sel_rise |=> !irq_o ##1 !irq_o)
    else $error("Interrupt not cleared at select rise");

  a_rx_word: assert property (
    (s.st == ssp_pkg::st_shift && samp && last && !cfg_i.p2s
     && !cfg_i.len8 && !cfg_i.adc_buf_en)
    |=> (rx_word_o == $past(shifted)))
    else $error("Received word differs from shifted bits");

  a_load_long: assert property (
    (s.st == ssp_pkg::st_load && s.synccnt == 2'h0 && !cfg_i.len8)
    |=> (s.sreg == {$past(par_i.cnt0), $past(par_i.cnt1)}))
    else $error("Long load took the wrong sources");

  // Checks below watch registered state and the cfg_i and par_i inputs; link
  // inputs are seen through the synchronisers, so every link antecedent is two
  // core cycles late against the pins and free of metastable values.

  // Last sample of a received word
  sequence s_rx_last;
    s.st == ssp_pkg::st_shift && samp && last && !cfg_i.p2s;
  endsequence

  // A complete received word is offered to the buffer
  a_push_on_word: assert property (
    s_rx_last |=> s.push)
    else $error("Received word not offered to the buffer");

  // Short receive leaves the upper byte alone
  a_short_keeps_hi: assert property (
    (s.st == ssp_pkg::st_shift && samp && last && !cfg_i.p2s && cfg_i.len8)
    |=> (rx_word_o.hi == $past(rx_word_o.hi)))
    else $error("Short receive changed the upper byte");

  // Short load source and cleared upper byte
  a_load_short: assert property (
    (s.st == ssp_pkg::st_load && s.synccnt == 2'h0 && cfg_i.len8)
    |=> (s.sreg.hi == 8'h00
         && s.sreg.lo == $past(cfg_i.src_adc ? par_i.adc : par_i.cnt0)))
    else $error("Short load took the wrong source");

  // Bit count starts over at every frame
  a_count_restart: assert property (
    (s.st == ssp_pkg::st_idle && sel_fall)
    |=> (s.bitcnt == 5'h00))
    else $error("Bit count not cleared at select fall");

  // Buffer mode takes the ADC result one cycle after its clock
  a_adc_capture: assert property (
    (s.adc_pend && s.st != ssp_pkg::st_shift)
    |=> (rx_word_o.lo == $past(par_i.adc)))
    else $error("ADC sample not captured in buffer mode");

  // Output stays driven until the frame ends
  a_oe_hold: assert property (
    (!miso_oe_n_o && !sel_rise) |=> !miso_oe_n_o)
    else $error("Output released inside a frame");

  // Stall only while a load is pending
  a_sync_in_load: assert property (
    sync_o |-> (s.st == ssp_pkg::st_load))
    else $error("Stall raised outside a load");

  // Next bit leaves from the top of the chosen length
  a_miso_msb: assert property (
    (s.st == ssp_pkg::st_shift && chg && cfg_i.p2s)
    |=> (miso_o == $past(cfg_i.len8 ? s.sreg.lo[7] : s.sreg.hi[7])))
    else $error("Serial output bit out of order");

  // Edges after the last bit are ignored until the frame ends
  a_done_holds: assert property (
    (s.st == ssp_pkg::st_done && !sel_rise)
    |=> (s.st == ssp_pkg::st_done))
    else $error("Sequencer left the done state inside a frame");

endmodule : ssp_converter

// file: ssp_master.sv
// Behavioural master that drives the converter's serial link.
// Assumes the core clock is free running; all link timing counts its
// falling edges so that every link change lands off the sampling edge.
module ssp_master (
  // Time base
  input wire logic mclk_i,
  // Link towards the converter
  output logic sclk_o,
  output logic chip_select_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_n_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Link timing
  // ****************************************************************
  localparam int HALF = 10;  // Half link period, 250 ns in core cycles

  // Idle link: select high, clock low
  initial begin
    sclk_o = 1'b0;
    chip_select_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // ****************************************************************
  // One framed transfer, most significant bit first
  // ****************************************************************
  task automatic xfer(input logic cpol, input logic cpha, input int nbits,
                      input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    sclk_o = cpol;  // Idle level set before the frame
    repeat (HALF) @(negedge mclk_i);
    chip_select_n_o = 1'b0;
    if (!cpha) mosi_o = tx[nbits-1];  // First bit set up early
    repeat (HALF) @(negedge mclk_i);
    for (int i = nbits - 1; i >= 0; i--) begin
      // Leading edge: sample for phase 0, change for phase 1
      sclk_o = ~cpol;
      if (cpha) mosi_o = tx[i];
      repeat (HALF) @(negedge mclk_i);
      // Undriven output reads as unknown so it can never match
      if (cpha) rx = {rx[14:0], miso_oe_n_i === 1'b0 ? miso_i : 1'bx};
      sclk_o = cpol;  // Trailing edge
      if (!cpha && i > 0) mosi_o = tx[i-1];
      repeat (HALF) @(negedge mclk_i);
    end
    chip_select_n_o = 1'b1;
    mosi_o = ~mosi_o;  // Released line no longer shows the last bit
    repeat (2 * HALF) @(negedge mclk_i);
  endtask
endmodule // ssp_master

// file: testbench.sv
// Self-checking bench for the slave serial/parallel converter.
// Assumes the design package is compiled first and the master model
// provides the link; inputs change on the falling core clock edge.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic mclk_i, rst_n_i, sclk, csn, mosi, miso, miso_oe_n, adc_clk;
  logic irq, sync, rx_valid, rx_ready, rx_overrun;
  ssp_pkg::ssp_cfg_s cfg;  // Configuration bits
  ssp_pkg::ssp_par_s par;  // Parallel sources
  ssp_pkg::ssp_word_s rx_word;  // Word to the cells
  logic [15:0] rx_data, got, w;
  int bad_count, checks_done, sync_run, sync_len, ovr_cnt;
  logic irq_seen, oe_seen;  // Sticky event flags per frame

  // Design under test
  ssp_converter ssp_converter_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
    .chip_select_n_i(csn), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_n_o(miso_oe_n), .cfg_i(cfg), .par_i(par),
    .adc_clk_i(adc_clk), .rx_word_o(rx_word), .irq_o(irq),
    .sync_o(sync), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .rx_overrun_o(rx_overrun));

  // Link master
  ssp_master ssp_master_inst (
    .mclk_i(mclk_i), .sclk_o(sclk), .chip_select_n_o(csn),
    .mosi_o(mosi), .miso_i(miso), .miso_oe_n_i(miso_oe_n));

  // 40 MHz core clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Event monitors: interrupt, drive, overrun, stall length
  always @(posedge mclk_i) begin
    if (irq === 1'b1) irq_seen <= 1'b1;
    if (miso_oe_n === 1'b0) oe_seen <= 1'b1;
    if (rx_overrun === 1'b1) ovr_cnt <= ovr_cnt + 1;
    if (sync === 1'b1) sync_run <= sync_run + 1;
    else if (sync_run != 0) begin
      sync_len <= sync_run;
      sync_run <= 0;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      bad_count++;
    end
  endtask

  // One frame in the given mode; interrupt seen, then cleared
  task automatic frame(input logic p, input logic h, input int n,
                       input logic [15:0] tx);
    irq_seen = 1'b0;
    oe_seen = 1'b0;
    sync_len = 0;  // Stale stall length must not carry over
    cfg.cpol = p;
    cfg.cpha = h;
    ssp_master_inst.xfer(p, h, n, tx, got);
    chk(16'(irq_seen), 16'h0001);
    chk(16'(irq), 16'h0000);
  endtask

  // Take one word from the buffer head
  task automatic pop(input logic [15:0] e);
    chk(16'(rx_valid), 16'h0001);
    chk(rx_data, e);
    rx_ready = 1'b1;
    @(negedge mclk_i);
    rx_ready = 1'b0;
    // An edge passes before the next pop raises ready again
    @(negedge mclk_i);
  endtask

  // Counts, verdict and end of run
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge mclk_i);
    bad_count++;
    test_done;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n_i = 1'b0;
    adc_clk = 1'b0;
    rx_ready = 1'b0;
    cfg = '0;
    par = '{cnt0: 8'hc3, cnt1: 8'h5a, adc: 8'h96};
    bad_count = 0;
    checks_done = 0;
    sync_run = 0;
    sync_len = 0;
    ovr_cnt = 0;
    irq_seen = 1'b0;
    oe_seen = 1'b0;
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    chk(16'({irq, sync, rx_valid, rx_overrun, miso_oe_n}), 16'h0001);
    repeat (3) @(negedge mclk_i);
    // Receive in all four clock modes
    for (int m = 0; m < 4; m++) begin
      w = 16'h8c31 ^ {4{4'(m)}};
      frame(m[1], m[0], 16, w);
      chk(rx_word, w);
      pop(w);
      chk(16'(oe_seen), 16'h0000);
    end
    // Short receive keeps the upper byte
    cfg.len8 = 1'b1;
    frame(1'b0, 1'b0, 8, 16'h00e7);
    chk(rx_word, {w[15:8], 8'he7});
    pop({w[15:8], 8'he7});
    cfg.len8 = 1'b0;
    // Fill the buffer past its depth, then drain it
    for (int k = 0; k < 17; k++) begin
      frame(1'b0, 1'b1, 16, 16'ha500 + 16'(k));
    end
    chk(16'(ovr_cnt), 16'h0001);
    for (int k = 0; k < 16; k++) pop(16'ha500 + 16'(k));
    chk(16'(rx_valid), 16'h0000);
    // Sample buffer mode captures the ADC result
    cfg.adc_buf_en = 1'b1;
    adc_clk = 1'b1;
    repeat (4) @(negedge mclk_i);
    adc_clk = 1'b0;
    repeat (6) @(negedge mclk_i);
    chk(16'(rx_word.lo), 16'h0096);
    cfg.adc_buf_en = 1'b0;
    // Long send in both polarities
    cfg.p2s = 1'b1;
    for (int p = 0; p < 2; p++) begin
      frame(p[0], 1'b1, 16, 16'h0000);
      chk(got, {8'hc3, 8'h5a});
      chk(16'(sync_len), 16'(ssp_pkg::SYNC_CYC));
      chk(16'({oe_seen, miso_oe_n}), 16'h0003);
    end
    // Short send from each source
    cfg.len8 = 1'b1;
    for (int s = 0; s < 2; s++) begin
      cfg.src_adc = s[0];
      frame(1'b1, 1'b1, 8, 16'h0000);
      chk(got, s[0] ? 16'h0096 : 16'h00c3);
    end
    // Phase 0 never drives the output
    cfg.len8 = 1'b0;
    frame(1'b0, 1'b0, 16, 16'h1234);
    chk(16'(oe_seen), 16'h0000);
    test_done;
  end
endmodule // testbench
